// ---- rtl/duab_pkg.sv ----
// Function
// - Port 1 doubling bit doubles mode 2 rate
// - Select bit steers port 1 control bit 7
// - Port 0 buffer write loads and starts transmit
// - Port 0 buffer read returns receive register
// - Port 1 buffer write loads and starts transmit
// - Port 1 buffer read returns receive register
// - Port 0 enable gates transmit/receive done interrupt
// - Port 1 enable gates transmit/receive done interrupt
// - Own address byte holds port 0 slave address
// - Mask zero bits are don't-care in address
// - Multiprocessor mode accepts addressed frames with bit9 set
// - Hardware sets frame error, software only clears
package duab_pkg;
  localparam int CLK_HZ  = 25_000_000;
  localparam int BAUD_HZ = 9600;
  // Bit period in clock cycles, rounded down
  localparam logic [15:0] BIT_CYC_STD   = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] MODE2_CYC     = 16'h0040;
  localparam logic [15:0] MODE2_CYC_DBL = 16'h0020;

  localparam int          AXI_AW = 10;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [7:0]  REG_RESET   = 8'h00;

  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_U0_DATA  = 8'h99;
  localparam logic [7:0] IDX_U1_DATA  = 8'h9a;
  localparam logic [7:0] IDX_EXTENDED_INTERRUPT_ENABLE_ONE     = 8'h9c;
  localparam logic [7:0] IDX_IE       = 8'ha8;
  localparam logic [7:0] IDX_U0_ADDR  = 8'ha9;
  localparam logic [7:0] IDX_U0_MASK  = 8'hb9;
  localparam logic [7:0] IDX_TIMER_THREE_CONTROL    = 8'hc4;
  localparam logic [7:0] IDX_U0_CTRL  = 8'hd0;
  localparam logic [7:0] IDX_U1_CTRL  = 8'hd1;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hd2;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hd3;

  // Field positions
  localparam int T3_DBL   = 7;
  localparam int T3_FESEL = 6;
  localparam int IE_ES    = 4;
  localparam int EXTENDED_INTERRUPT_ENABLE_ONE_ES1 = 0;
  localparam int CTRL_SM0 = 7;
  localparam int CTRL_TI  = 1;
  localparam int CTRL_RI  = 0;
  localparam int ST_TI0   = 0;
  localparam int ST_RI0   = 1;
  localparam int ST_TI1   = 2;
  localparam int ST_RI1   = 3;
  localparam int ST_FE1   = 4;

  typedef struct packed {
    logic [1:0]  mode;
    logic        sm2;
    logic        ren;
    logic        tb8;
    logic [15:0] bit_cyc;
    logic [7:0]  addr;
    logic [7:0]  mask;
  } duab_cfg_t;

  typedef struct packed {
    logic       tx_done;
    logic       rx_done;
    logic       fe;
    logic       rb8;
    logic [7:0] rx_data;
  } duab_evt_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} duab_rx_state_t;
endpackage

// ---- rtl/duab_serial.sv ----
`timescale 1ns/10ps
`default_nettype none
module duab_serial (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire duab_pkg::duab_cfg_t cfg,
  input  wire logic                tx_start,
  input  wire logic [7:0]          tx_data,
  input  wire logic                rxd,
  output logic                     txd,
  output duab_pkg::duab_evt_t      evt
);
  import duab_pkg::*;

  logic [10:0]    tx_sh;
  logic [3:0]     tx_cnt;
  logic [15:0]    tx_tmr;
  logic           tx_busy;
  logic           tx_done;
  duab_rx_state_t rx_state;
  logic [8:0]     rx_sh;
  logic [3:0]     rx_cnt;
  logic [15:0]    rx_tmr;
  logic           rx_prev;
  logic           rx_done;
  logic           rx_fe;
  logic           rx_b8;
  logic [7:0]     rx_data;

  wire       nine     = cfg.mode[1];
  wire       tx_end   = (tx_tmr == cfg.bit_cyc - 16'h0001);
  wire       rx_end   = (rx_tmr == cfg.bit_cyc - 16'h0001);
  wire       rx_half  = (rx_tmr == {1'b0, cfg.bit_cyc[15:1]});
  wire [3:0] tx_last  = nine ? 4'ha : 4'h9;
  wire [3:0] rx_last  = nine ? 4'h8 : 4'h7;
  wire [7:0] rx_byte  = nine ? rx_sh[7:0] : rx_sh[8:1];
  wire       rx_bit9  = nine ? rx_sh[8] : rxd;
  wire       given    = (((rx_byte ^ cfg.addr) & cfg.mask) == 8'h00);
  wire       bcast    = &(rx_byte | ~(cfg.addr | cfg.mask));
  wire       accept   = !cfg.sm2 || (rx_bit9 && (given || bcast));

  assign txd = tx_sh[0];
  assign evt = '{tx_done: tx_done, rx_done: rx_done, fe: rx_fe, rb8: rx_b8, rx_data: rx_data};

  // Writes while a frame is still leaving are ignored
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh   <= 11'h7ff;
      tx_cnt  <= 4'h0;
      tx_tmr  <= 16'h0000;
      tx_busy <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (!tx_busy) begin
        if (tx_start) begin
          tx_sh   <= {1'b1, nine ? cfg.tb8 : 1'b1, tx_data, 1'b0};
          tx_busy <= 1'b1;
          tx_cnt  <= 4'h0;
          tx_tmr  <= 16'h0000;
        end
      end else if (tx_end) begin
        tx_tmr <= 16'h0000;
        tx_sh  <= {1'b1, tx_sh[10:1]};
        if (tx_cnt == tx_last) begin
          tx_busy <= 1'b0;
          tx_done <= 1'b1;
        end else begin
          tx_cnt <= tx_cnt + 4'h1;
        end
      end else begin
        tx_tmr <= tx_tmr + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state <= RX_IDLE;
      rx_sh    <= 9'h000;
      rx_cnt   <= 4'h0;
      rx_tmr   <= 16'h0000;
      rx_prev  <= 1'b1;
      rx_done  <= 1'b0;
      rx_fe    <= 1'b0;
      rx_b8    <= 1'b0;
      rx_data  <= 8'h00;
    end else begin
      rx_prev <= rxd;
      rx_done <= 1'b0;
      rx_fe   <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_tmr <= 16'h0000;
          if (cfg.ren && rx_prev && !rxd) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          // A start bit that is high again at mid-bit is a glitch
          if (rx_half) begin
            rx_tmr   <= 16'h0000;
            rx_cnt   <= 4'h0;
            rx_state <= rxd ? RX_IDLE : RX_DATA;
          end else begin
            rx_tmr <= rx_tmr + 16'h0001;
          end
        end
        RX_DATA: begin
          if (rx_end) begin
            rx_tmr <= 16'h0000;
            rx_sh  <= {rxd, rx_sh[8:1]};
            if (rx_cnt == rx_last) begin
              rx_state <= RX_STOP;
            end else begin
              rx_cnt <= rx_cnt + 4'h1;
            end
          end else begin
            rx_tmr <= rx_tmr + 16'h0001;
          end
        end
        RX_STOP: begin
          if (rx_end) begin
            rx_tmr   <= 16'h0000;
            rx_state <= RX_IDLE;
            rx_fe    <= !rxd;
            if (accept) begin
              rx_data <= rx_byte;
              rx_b8   <= rx_bit9;
              rx_done <= 1'b1;
            end
          end else begin
            rx_tmr <= rx_tmr + 16'h0001;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
endmodule // duab_serial
`default_nettype wire

// ---- rtl/duab_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module duab_top (
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  input  wire logic [duab_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input  wire logic                        S_AXI_AWVALID,
  output logic                             S_AXI_AWREADY,
  input  wire logic [31:0]                 S_AXI_WDATA,
  input  wire logic [3:0]                  S_AXI_WSTRB,
  input  wire logic                        S_AXI_WVALID,
  output logic                             S_AXI_WREADY,
  output logic [1:0]                       S_AXI_BRESP,
  output logic                             S_AXI_BVALID,
  input  wire logic                        S_AXI_BREADY,
  input  wire logic [duab_pkg::AXI_AW-1:0] S_AXI_ARADDR,
  input  wire logic                        S_AXI_ARVALID,
  output logic                             S_AXI_ARREADY,
  output logic [31:0]                      S_AXI_RDATA,
  output logic [1:0]                       S_AXI_RRESP,
  output logic                             S_AXI_RVALID,
  input  wire logic                        S_AXI_RREADY,
  input  wire logic                        RXD0,
  input  wire logic                        RXD1,
  output logic                             TXD0,
  output logic                             TXD1,
  output logic                             IRQ,
  output logic                             IRQ_UART0,
  output logic                             IRQ_UART1
);
  import duab_pkg::*;

  // Bus state
  logic                  aw_held;
  logic                  w_held;
  logic [AXI_AW-1:0]     aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane0;
  logic                  ar_rdy;

  // Software-visible storage
  logic [7:2]            u0_ctrl;
  logic [6:2]            u1_ctrl;
  logic                  u1_mode0;
  logic [7:0]            ie_reg;
  logic [7:0]            extended_interrupt_enable_one_reg;
  logic [7:0]            u0_addr;
  logic [7:0]            u0_mask;
  logic [7:0]            timer_three_control;
  logic [4:0]            irq_stat;
  logic [4:0]            irq_mask;

  duab_cfg_t             u0_cfg;
  duab_cfg_t             u1_cfg;
  duab_evt_t             u0_evt;
  duab_evt_t             u1_evt;
  logic                  tx0_line;
  logic                  tx1_line;

  // Write path decode
  wire        wr_fire   = aw_held && w_held && !S_AXI_BVALID;
  wire [7:0]  wr_idx    = aw_addr[AXI_AW-1:2];
  wire        wr_en     = wr_fire && w_lane0;
  wire        ws_u0d    = wr_en && (wr_idx == IDX_U0_DATA);
  wire        ws_u1d    = wr_en && (wr_idx == IDX_U1_DATA);
  wire        ws_extended_interrupt_enable_one   = wr_en && (wr_idx == IDX_EXTENDED_INTERRUPT_ENABLE_ONE);
  wire        ws_ie     = wr_en && (wr_idx == IDX_IE);
  wire        ws_u0a    = wr_en && (wr_idx == IDX_U0_ADDR);
  wire        ws_u0m    = wr_en && (wr_idx == IDX_U0_MASK);
  wire        ws_t3     = wr_en && (wr_idx == IDX_TIMER_THREE_CONTROL);
  wire        ws_u0c    = wr_en && (wr_idx == IDX_U0_CTRL);
  wire        ws_u1c    = wr_en && (wr_idx == IDX_U1_CTRL);
  wire        ws_stat   = wr_en && (wr_idx == IDX_IRQ_STAT);
  wire        ws_mask   = wr_en && (wr_idx == IDX_IRQ_MASK);
  wire        wr_known  = (wr_idx == IDX_U0_DATA) || (wr_idx == IDX_U1_DATA) ||
                          (wr_idx == IDX_EXTENDED_INTERRUPT_ENABLE_ONE) || (wr_idx == IDX_IE) ||
                          (wr_idx == IDX_U0_ADDR) || (wr_idx == IDX_U0_MASK) ||
                          (wr_idx == IDX_TIMER_THREE_CONTROL) || (wr_idx == IDX_U0_CTRL) ||
                          (wr_idx == IDX_U1_CTRL) || (wr_idx == IDX_IRQ_STAT) ||
                          (wr_idx == IDX_IRQ_MASK);

  wire        fe_sel    = timer_three_control[T3_FESEL];
  wire        baud_dbl  = timer_three_control[T3_DBL];

  // Status: hardware events set, software clears; a set wins a same-cycle clear
  wire [4:0]  stat_set  = {u1_evt.fe, u1_evt.rx_done, u1_evt.tx_done,
                           u0_evt.rx_done, u0_evt.tx_done};
  wire [4:0]  clr_w1c   = ws_stat ? w_byte[4:0] : 5'h00;
  wire [4:0]  clr_ctl0  = ws_u0c ? {3'h0, ~w_byte[CTRL_RI], ~w_byte[CTRL_TI]} : 5'h00;
  wire [4:0]  clr_ctl1  = ws_u1c ? {fe_sel & ~w_byte[CTRL_SM0], ~w_byte[CTRL_RI],
                                    ~w_byte[CTRL_TI], 2'h0} : 5'h00;
  wire [4:0]  next_stat = (irq_stat & ~(clr_w1c | clr_ctl0 | clr_ctl1)) | stat_set;

  // Control bit 7 of port 1 is the mode bit or the frame error flag
  wire        u1_bit7   = fe_sel ? irq_stat[ST_FE1] : u1_mode0;
  wire [7:0]  u0_ctrl_rd = {u0_ctrl, irq_stat[ST_TI0], irq_stat[ST_RI0]};
  wire [7:0]  u1_ctrl_rd = {u1_bit7, u1_ctrl, irq_stat[ST_TI1], irq_stat[ST_RI1]};

  wire [1:0]  u1_mode   = {u1_mode0, u1_ctrl[6]};
  wire [15:0] u1_cyc    = (u1_mode == 2'h2) ? (baud_dbl ? MODE2_CYC_DBL : MODE2_CYC)
                                            : BIT_CYC_STD;
  wire [1:0]  u0_mode   = u0_ctrl[7:6];
  wire [15:0] u0_cyc    = (u0_mode == 2'h2) ? MODE2_CYC : BIT_CYC_STD;

  // Read path decode
  wire [7:0]  rd_idx    = S_AXI_ARADDR[AXI_AW-1:2];
  wire        ar_fire   = S_AXI_ARVALID && ar_rdy;
  wire        rs_u0d    = (rd_idx == IDX_U0_DATA);
  wire        rs_u1d    = (rd_idx == IDX_U1_DATA);
  wire        rs_extended_interrupt_enable_one   = (rd_idx == IDX_EXTENDED_INTERRUPT_ENABLE_ONE);
  wire        rs_ie     = (rd_idx == IDX_IE);
  wire        rs_u0a    = (rd_idx == IDX_U0_ADDR);
  wire        rs_u0m    = (rd_idx == IDX_U0_MASK);
  wire        rs_t3     = (rd_idx == IDX_TIMER_THREE_CONTROL);
  wire        rs_u0c    = (rd_idx == IDX_U0_CTRL);
  wire        rs_u1c    = (rd_idx == IDX_U1_CTRL);
  wire        rs_stat   = (rd_idx == IDX_IRQ_STAT);
  wire        rs_mask   = (rd_idx == IDX_IRQ_MASK);
  wire        rd_known  = rs_u0d | rs_u1d | rs_extended_interrupt_enable_one | rs_ie | rs_u0a | rs_u0m |
                          rs_t3 | rs_u0c | rs_u1c | rs_stat | rs_mask;
  wire [7:0]  rd_byte   = ({8{rs_u0d}}  & u0_evt.rx_data) |
                          ({8{rs_u1d}}  & u1_evt.rx_data) |
                          ({8{rs_extended_interrupt_enable_one}} & extended_interrupt_enable_one_reg) |
                          ({8{rs_ie}}   & ie_reg) |
                          ({8{rs_u0a}}  & u0_addr) |
                          ({8{rs_u0m}}  & u0_mask) |
                          ({8{rs_t3}}   & timer_three_control) |
                          ({8{rs_u0c}}  & u0_ctrl_rd) |
                          ({8{rs_u1c}}  & u1_ctrl_rd) |
                          ({8{rs_stat}} & {3'h0, irq_stat}) |
                          ({8{rs_mask}} & {3'h0, irq_mask});

  // Port 1 has no address registers here, so a zero mask lets every address through
  assign u0_cfg = '{mode: u0_mode, sm2: u0_ctrl[5], ren: u0_ctrl[4], tb8: u0_ctrl[3],
                    bit_cyc: u0_cyc, addr: u0_addr, mask: u0_mask};
  assign u1_cfg = '{mode: u1_mode, sm2: u1_ctrl[5], ren: u1_ctrl[4], tb8: u1_ctrl[3],
                    bit_cyc: u1_cyc, addr: REG_RESET, mask: REG_RESET};

  duab_serial u_port0 (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .cfg      (u0_cfg),
    .tx_start (ws_u0d),
    .tx_data  (w_byte),
    .rxd      (RXD0),
    .txd      (tx0_line),
    .evt      (u0_evt)
  );

  duab_serial u_port1 (
    .clk      (CLK),
    .arst_n   (ARST_N),
    .cfg      (u1_cfg),
    .tx_start (ws_u1d),
    .tx_data  (w_byte),
    .rxd      (RXD1),
    .txd      (tx1_line),
    .evt      (u1_evt)
  );

  // Write address and data are taken independently, in either order
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held       <= 1'b0;
      S_AXI_AWREADY <= 1'b1;
      aw_addr       <= '0;
    end else if (aw_held) begin
      if (wr_fire) begin
        aw_held       <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
      end
    end else if (S_AXI_AWVALID) begin
      aw_held       <= 1'b1;
      S_AXI_AWREADY <= 1'b0;
      aw_addr       <= S_AXI_AWADDR;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      w_held       <= 1'b0;
      S_AXI_WREADY <= 1'b1;
      w_byte       <= REG_RESET;
      w_lane0      <= 1'b0;
    end else if (w_held) begin
      if (wr_fire) begin
        w_held       <= 1'b0;
        S_AXI_WREADY <= 1'b1;
      end
    end else if (S_AXI_WVALID) begin
      w_held       <= 1'b1;
      S_AXI_WREADY <= 1'b0;
      w_byte       <= S_AXI_WDATA[7:0];
      w_lane0      <= S_AXI_WSTRB[0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // One read under way; address ready drops until the data is taken
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ar_rdy       <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (ar_fire) begin
      ar_rdy       <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= {24'h00_0000, rd_byte};
      S_AXI_RRESP  <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      ar_rdy       <= 1'b1;
      S_AXI_RVALID <= 1'b0;
    end
  end

  assign S_AXI_ARREADY = ar_rdy;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ie_reg   <= REG_RESET;
      extended_interrupt_enable_one_reg <= REG_RESET;
      u0_addr  <= REG_RESET;
      u0_mask  <= REG_RESET;
      timer_three_control    <= REG_RESET;
      irq_mask <= 5'h00;
    end else begin
      if (ws_ie) ie_reg <= w_byte;
      if (ws_extended_interrupt_enable_one) extended_interrupt_enable_one_reg <= w_byte;
      if (ws_u0a) u0_addr <= w_byte;
      if (ws_u0m) u0_mask <= w_byte;
      if (ws_t3) timer_three_control <= w_byte;
      if (ws_mask) irq_mask <= w_byte[4:0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      u0_ctrl  <= 6'h00;
      u1_ctrl  <= 5'h00;
      u1_mode0 <= 1'b0;
    end else begin
      if (ws_u0c) u0_ctrl <= w_byte[7:2];
      if (ws_u1c) u1_ctrl <= w_byte[6:2];
      if (ws_u1c && !fe_sel) u1_mode0 <= w_byte[CTRL_SM0];
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat  <= 5'h00;
      IRQ       <= 1'b0;
      IRQ_UART0 <= 1'b0;
      IRQ_UART1 <= 1'b0;
      TXD0      <= 1'b1;
      TXD1      <= 1'b1;
    end else begin
      irq_stat  <= next_stat;
      IRQ       <= |(next_stat & irq_mask);
      IRQ_UART0 <= ie_reg[IE_ES] & (next_stat[ST_TI0] | next_stat[ST_RI0]);
      IRQ_UART1 <= extended_interrupt_enable_one_reg[EXTENDED_INTERRUPT_ENABLE_ONE_ES1] & (next_stat[ST_TI1] | next_stat[ST_RI1]);
      TXD0      <= tx0_line;
      TXD1      <= tx1_line;
    end
  end
endmodule // duab_top
`default_nettype wire

// ---- tb/duab_node.sv ----
`timescale 1ns/10ps
`default_nettype none
module duab_node (
  input  wire logic CLK,
  input  wire logic TXD,
  output var logic  RXD
);
  // Line idles high between frames
  initial RXD = 1'b1;
  // Start, 8 data LSB first, ninth, stop
  task automatic send(input logic [7:0] d, input logic b9, input logic stp, input int cyc);
    logic [10:0] f;
    f = {stp, b9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge CLK);
      RXD <= f[i];
      repeat (cyc - 1) @(posedge CLK);
    end
    @(posedge CLK);
    RXD <= 1'b1;
  endtask
  // Samples mid bit; ninth bit lands in v[8]
  task automatic grab(input int cyc, output logic [8:0] v);
    int n;
    n = 0;
    while (TXD && n < 4000) begin
      @(negedge CLK);
      n++;
    end
    repeat (cyc / 2) @(negedge CLK);
    for (int i = 0; i < 9; i++) begin
      repeat (cyc) @(negedge CLK);
      v[i] = TXD;
    end
  endtask
endmodule // duab_node
`default_nettype wire

// ---- tb/duab_top_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module duab_top_assertions (
  input wire logic                        CLK,
  input wire logic                        ARST_N,
  input wire logic [duab_pkg::AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic                        S_AXI_AWVALID,
  input wire logic                        S_AXI_AWREADY,
  input wire logic [31:0]                 S_AXI_WDATA,
  input wire logic [3:0]                  S_AXI_WSTRB,
  input wire logic                        S_AXI_WVALID,
  input wire logic                        S_AXI_WREADY,
  input wire logic [1:0]                  S_AXI_BRESP,
  input wire logic                        S_AXI_BVALID,
  input wire logic                        S_AXI_BREADY,
  input wire logic                        S_AXI_ARVALID,
  input wire logic                        S_AXI_ARREADY,
  input wire logic [31:0]                 S_AXI_RDATA,
  input wire logic                        S_AXI_RVALID,
  input wire logic                        S_AXI_RREADY,
  input wire logic                        TXD0,
  input wire logic                        TXD1,
  input wire logic                        IRQ_UART0,
  input wire logic                        IRQ_UART1
);
  import duab_pkg::*;
  logic [7:0] aw_idx;
  logic [7:0] w_byte;
  logic       w_en;
  logic       bv_q;
  logic       en0;
  logic       en1;
  wire        fire = S_AXI_BVALID && !bv_q && w_en;
  // Shadow of the two enables, so gating is judged from bus traffic alone
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {aw_idx, w_byte, w_en, bv_q, en0, en1} <= '0;
    end else begin
      bv_q <= S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_idx <= S_AXI_AWADDR[9:2];
      if (S_AXI_WVALID && S_AXI_WREADY) w_byte <= S_AXI_WDATA[7:0];
      if (S_AXI_WVALID && S_AXI_WREADY) w_en <= S_AXI_WSTRB[0];
      if (fire && aw_idx == IDX_IE) en0 <= w_byte[IE_ES];
      if (fire && aw_idx == IDX_EXTENDED_INTERRUPT_ENABLE_ONE) en1 <= w_byte[EXTENDED_INTERRUPT_ENABLE_ONE_ES1];
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  a_bvalid_drop: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID)
    else $error("write response not released");
  a_rvalid_drop: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY)
    else $error("read response not released");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read not answered next cycle");
  a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |=> !S_AXI_AWREADY && !S_AXI_WREADY ##1 S_AXI_BVALID)
    else $error("write not answered in time");
  a_unmapped_err: assert property (S_AXI_BVALID && !bv_q && aw_idx < 8'h99 |-> S_AXI_BRESP == RESP_SLVERR)
    else $error("unmapped write not refused");
  a_txd0_bit: assert property ($changed(TXD0) |=> $stable(TXD0) [*7])
    else $error("port 0 bit too short");
  a_txd1_bit: assert property ($changed(TXD1) |=> $stable(TXD1) [*7])
    else $error("port 1 bit too short");
  a_irq0_gate: assert property (!en0 |-> !IRQ_UART0)
    else $error("port 0 interrupt while disabled");
  a_irq1_gate: assert property (!en1 |-> !IRQ_UART1)
    else $error("port 1 interrupt while disabled");
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
  c_tx1: cover property ($fell(TXD1));
  c_irq0: cover property ($rose(IRQ_UART0));
endmodule // duab_top_assertions
bind duab_top duab_top_assertions duab_top_assertions_i (.*);
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (a), (b)); end end
module tb_top;
  import duab_pkg::*;
  localparam logic [7:0] REGS [7] = '{IDX_U0_DATA, IDX_U1_DATA, IDX_EXTENDED_INTERRUPT_ENABLE_ONE, IDX_IE,
                                      IDX_U0_ADDR, IDX_U0_MASK, IDX_TIMER_THREE_CONTROL};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0, d, rdata;
  logic [3:0]  wstrb = 4'h1;
  logic        awready, wready, bvalid, arready, rvalid, txd0, txd1, rxd0, rxd1;
  logic        irq, irq0, irq1, e;
  logic [1:0]  bresp, rresp, rp;
  logic [7:0]  v, a, m, b;
  logic [8:0]  f;
  int          error_cnt = 0, tests_run = 0, s;
  always #20 clk = ~clk;
  duab_top duab_top_i (.CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RXD0(rxd0), .RXD1(rxd1), .TXD0(txd0), .TXD1(txd1), .IRQ(irq),
    .IRQ_UART0(irq0), .IRQ_UART1(irq1));
  duab_node u0_node (.CLK(clk), .TXD(txd0), .RXD(rxd0));
  duab_node u1_node (.CLK(clk), .TXD(txd1), .RXD(rxd1));
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // No cycle limit here: only the watchdog ends a wait
  task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h00_0000, dat};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awv <= 1'b0;
      if (wready) wv <= 1'b0;
    end while (bvalid !== 1'b1);
    rp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arv <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    rp = rresp;
    rready <= 1'b0;
  endtask
  // Given address under the mask, or broadcast
  function automatic logic accept(input logic [7:0] bb, input logic [7:0] aa, input logic [7:0] mm);
    return (((bb ^ aa) & mm) == 8'h00) || ((bb & (aa | mm)) == (aa | mm));
  endfunction
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    close_out;
  end
  initial begin
    s = $urandom(32'hb3ab);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    foreach (REGS[i]) begin
      rd(REGS[i]);
      `CHK(d, 32'h0000_0000)
      `CHK(rp, RESP_OKAY)
    end
    rd(8'h00);
    `CHK(rp, RESP_SLVERR)
    wr(8'h00, 8'hff);
    `CHK(rp, RESP_SLVERR)
    // Strobe low must leave stored byte alone
    for (int i = 2; i < 7; i++) begin
      v = 8'($urandom);
      wr(REGS[i], v);
      wstrb <= 4'h0;
      wr(REGS[i], ~v);
      wstrb <= 4'h1;
      rd(REGS[i]);
      `CHK(d, {24'h00_0000, v})
    end
    wr(IDX_U0_CTRL, 8'h88);
    v = 8'($urandom);
    fork
      u0_node.grab(64, f);
      begin
        wr(IDX_U0_DATA, v);
        wr(IDX_U0_DATA, ~v);
      end
    join
    `CHK(f, {1'b1, v})
    // Ninth bit half gone plus the whole stop bit before the done flag
    repeat (120) @(posedge clk);
    rd(IDX_IRQ_STAT);
    `CHK(d[ST_TI0], 1'b1)
    rd(IDX_U0_DATA);
    `CHK(d, 32'h0000_0000)
    wr(IDX_IRQ_STAT, 8'h1f);
    a = 8'($urandom);
    m = 8'($urandom & $urandom);
    wr(IDX_U0_ADDR, a);
    wr(IDX_U0_MASK, m);
    wr(IDX_IE, 8'h10);
    wr(IDX_U0_CTRL, 8'hb0);
    for (int k = 0; k < 6; k++) begin
      b = (k == 0) ? (a ^ ~m) : (k == 1) ? 8'hff : (k == 3) ? (a ^ m) : 8'($urandom);
      e = (k != 2) && accept(b, a, m);
      u0_node.send(b, k != 2, 1'b1, 64);
      repeat (4) @(posedge clk);
      rd(IDX_IRQ_STAT);
      `CHK(d[ST_RI0], e)
      `CHK(irq0, e)
      rd(IDX_U0_DATA);
      if (e) `CHK(d[7:0], b)
      wr(IDX_IRQ_STAT, 8'h1f);
    end
    wr(IDX_IE, 8'h00);
    wr(IDX_U0_CTRL, 8'h90);
    u0_node.send(b, 1'b0, 1'b1, 64);
    repeat (4) @(posedge clk);
    `CHK(irq0, 1'b0)
    `CHK(irq, 1'b0)
    wr(IDX_IRQ_MASK, 8'h02);
    // Interrupt flop follows the mask one edge after the write lands
    @(negedge clk);
    `CHK(irq, 1'b1)
    wr(IDX_IRQ_STAT, 8'h02);
    @(negedge clk);
    `CHK(irq, 1'b0)
    wr(IDX_TIMER_THREE_CONTROL, 8'h80);
    wr(IDX_U1_CTRL, 8'h90);
    wr(IDX_EXTENDED_INTERRUPT_ENABLE_ONE, 8'h01);
    v = 8'($urandom);
    fork
      u1_node.grab(32, f);
      wr(IDX_U1_DATA, v);
    join
    `CHK(f, {1'b0, v})
    repeat (60) @(posedge clk);
    `CHK(irq1, 1'b1)
    wr(IDX_EXTENDED_INTERRUPT_ENABLE_ONE, 8'h00);
    @(negedge clk);
    `CHK(irq1, 1'b0)
    b = 8'($urandom);
    u1_node.send(b, 1'b0, 1'b1, 32);
    repeat (4) @(posedge clk);
    rd(IDX_U1_DATA);
    `CHK(d[7:0], b)
    // Bad stop bit with the error flag selected
    wr(IDX_TIMER_THREE_CONTROL, 8'hc0);
    u1_node.send(~b, 1'b0, 1'b0, 32);
    repeat (4) @(posedge clk);
    rd(IDX_U1_CTRL);
    `CHK(d[7], 1'b1)
    rd(IDX_IRQ_STAT);
    `CHK(d[ST_FE1], 1'b1)
    wr(IDX_U1_CTRL, 8'h10);
    rd(IDX_U1_CTRL);
    `CHK(d[7], 1'b0)
    wr(IDX_TIMER_THREE_CONTROL, 8'h80);
    rd(IDX_U1_CTRL);
    `CHK(d[7], 1'b1)
    close_out;
  end
endmodule // tb_top
`default_nettype wire
